// file: src/cfm_fail_safe_monitor.sv
// Fail-safe clock monitor with power-managed mode, reset and wake handling
`timescale 1ns/10ps
module cfm_fail_safe_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic prim_clk_i,
    input wire logic sec_clk_i,
    input wire logic slow_osc_i,
    input wire cfm_pkg::cfm_prim_mode_e prim_mode_i,
    input wire logic startup_timer_done_i,
    input wire logic pll_lock_done_i,
    input wire cfm_pkg::cfm_clk_src_e clk_sel_i,
    input wire logic clk_sel_wr_i,
    input wire logic pm_enter_i,
    input wire logic pm_sleep_i,
    input wire logic wake_irq_i,
    input wire logic fail_int_en_i,
    input wire logic fail_flag_clr_i,
    output cfm_pkg::cfm_clk_src_e clk_src_o,
    output logic fail_safe_o,
    output logic fail_flag_o,
    output logic startup_done_o,
    output logic prim_en_o,
    output logic cpu_run_o,
    output logic fail_wake_o,
    output logic monitor_armed_o
);
    import cfm_pkg::*;

    cfm_state_e state_r;
    cfm_state_e state_nxt;
    cfm_clk_src_e clk_sel_r;
    cfm_clk_src_e clk_sel_nxt;
    logic fail_safe_r;
    logic fail_safe_nxt;
    logic fail_flag_r;
    logic fail_flag_nxt;
    logic startup_done_r;
    logic startup_done_nxt;
    logic prim_en_r;
    logic prim_en_nxt;
    logic cpu_run_r;
    logic cpu_run_nxt;
    logic fail_wake_r;
    logic fail_wake_nxt;
    logic armed_r;
    logic armed_nxt;
    logic fail_det;
    logic crystal_mode;
    logic prim_stable;

    // Missing-edge detector on the source the system runs from
    cfm_edge_watch u_edge_watch (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .prim_clk_i(prim_clk_i),
        .sec_clk_i(sec_clk_i),
        .slow_osc_i(slow_osc_i),
        .watch_sec_i(clk_sel_r == SRC_SECONDARY),
        .armed_i(armed_r),
        .fail_o(fail_det)
    );

    // Crystal and resonator modes need the start-up wait
    assign crystal_mode = (prim_mode_i == MODE_HIGH_SPEED_CRYSTAL) ||
                          (prim_mode_i == MODE_HIGH_SPEED_CRYSTAL_MULT) ||
                          (prim_mode_i == MODE_LOW_POWER_CRYSTAL) ||
                          (prim_mode_i == MODE_STANDARD_CRYSTAL);

    // Lock timer only matters for the multiplied crystal mode
    assign prim_stable = startup_timer_done_i &&
                         (pll_lock_done_i || (prim_mode_i != MODE_HIGH_SPEED_CRYSTAL_MULT));

    // State and clock selection
    always_comb begin
        state_nxt = state_r;
        clk_sel_nxt = clk_sel_r;
        startup_done_nxt = startup_done_r;
        prim_en_nxt = prim_en_r;
        fail_wake_nxt = 1'b0;
        unique case (state_r)
            ST_STARTUP: begin
                if (pm_enter_i) begin
                    clk_sel_nxt = clk_sel_i;
                    state_nxt = pm_sleep_i ? ST_SLEEP : ST_PWR_MANAGED;
                    if (clk_sel_i != SRC_PRIMARY) begin
                        prim_en_nxt = 1'b0;
                    end
                end else if (!crystal_mode) begin
                    clk_sel_nxt = SRC_PRIMARY;
                    startup_done_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end else if (prim_stable) begin
                    // Internal block hands over; slow oscillator only samples now
                    clk_sel_nxt = SRC_PRIMARY;
                    startup_done_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end else begin
                    clk_sel_nxt = SRC_INTERNAL_OSC_MUX;
                end
            end
            ST_RUN: begin
                if (pm_enter_i) begin
                    clk_sel_nxt = clk_sel_i;
                    state_nxt = pm_sleep_i ? ST_SLEEP : ST_PWR_MANAGED;
                end else if (fail_det) begin
                    clk_sel_nxt = SRC_INTERNAL_OSC_MUX;
                end else if (clk_sel_wr_i && !fail_safe_r) begin
                    clk_sel_nxt = clk_sel_i;
                end
            end
            ST_PWR_MANAGED: begin
                if (fail_det) begin
                    clk_sel_nxt = SRC_INTERNAL_OSC_MUX;
                    if (fail_int_en_i) begin
                        state_nxt = ST_RUN;
                        fail_wake_nxt = 1'b1;
                    end
                end else if (wake_irq_i) begin
                    // Clock stays as is, so after a failure it is the internal mux
                    state_nxt = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake_irq_i) begin
                    // Wake restarts the start-up wait; primary must restart
                    state_nxt = ST_STARTUP;
                    startup_done_nxt = 1'b0;
                    prim_en_nxt = 1'b1;
                    clk_sel_nxt = SRC_INTERNAL_OSC_MUX;
                end
            end
        endcase
        // A failure that meets a mode change, or a stale one at sleep entry,
        // must still leave the failed source: the set beats any selection
        if (fail_det) begin
            clk_sel_nxt = SRC_INTERNAL_OSC_MUX;
        end
        cpu_run_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_STARTUP);
        // Watch only after start-up and never the fallback source itself
        armed_nxt = ((state_nxt == ST_RUN) || (state_nxt == ST_PWR_MANAGED)) &&
                    (clk_sel_nxt != SRC_INTERNAL_OSC_MUX);
    end

    // Fail-safe condition and interrupt flag; a new failure beats a clear
    always_comb begin
        fail_safe_nxt = fail_safe_r;
        fail_flag_nxt = fail_flag_r;
        if (pm_enter_i && ((state_r == ST_RUN) || (state_r == ST_STARTUP))) begin
            fail_safe_nxt = 1'b0;
        end
        if (fail_flag_clr_i) begin
            fail_flag_nxt = 1'b0;
        end
        if (fail_det) begin
            fail_safe_nxt = 1'b1;
            fail_flag_nxt = 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= STATE_RST;
            clk_sel_r <= CLK_SEL_RST;
            fail_safe_r <= FAIL_SAFE_RST;
            fail_flag_r <= FAIL_FLAG_RST;
            startup_done_r <= 1'b0;
            prim_en_r <= PRIM_EN_RST;
            cpu_run_r <= 1'b1;
            fail_wake_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            clk_sel_r <= clk_sel_nxt;
            fail_safe_r <= fail_safe_nxt;
            fail_flag_r <= fail_flag_nxt;
            startup_done_r <= startup_done_nxt;
            prim_en_r <= prim_en_nxt;
            cpu_run_r <= cpu_run_nxt;
            fail_wake_r <= fail_wake_nxt;
            armed_r <= armed_nxt;
        end
    end

    // Outputs straight from flops; firmware watches startup_done_o with a timeout
    assign clk_src_o = clk_sel_r;
    assign fail_safe_o = fail_safe_r;
    assign fail_flag_o = fail_flag_r;
    assign startup_done_o = startup_done_r;
    assign prim_en_o = prim_en_r;
    assign cpu_run_o = cpu_run_r;
    assign fail_wake_o = fail_wake_r;
    assign monitor_armed_o = armed_r;

    // Reset has proven no external source yet, so it must start on the internal mux
    if (CLK_SEL_RST != SRC_INTERNAL_OSC_MUX) begin : g_bad_rst_src
        $error("CLK_SEL_RST must select the internal oscillator mux");
    end

    // A primary held off after reset could never start, so start-up would hang
    if (PRIM_EN_RST != 1'b1) begin : g_bad_prim_rst
        $error("PRIM_EN_RST must enable the primary oscillator");
    end

    // Fail-safe and flag must leave reset clear, or a flag appears while unarmed
    if ((FAIL_SAFE_RST != 1'b0) || (FAIL_FLAG_RST != 1'b0)) begin : g_bad_fail_rst
        $error("Fail-safe and flag must reset clear");
    end

endmodule // cfm_fail_safe_monitor

// file: src/cfm_pkg.sv
// Package of shared types and constants for the clock fail monitor
package cfm_pkg;

    // Primary oscillator configuration modes
    typedef enum logic [2:0] {
        MODE_EXTERNAL_CLOCK_INPUT = 3'h0,
        MODE_RESISTOR_CAPACITOR = 3'h1,
        MODE_INTERNAL_SLOW_OSC = 3'h2,
        MODE_HIGH_SPEED_CRYSTAL = 3'h3,
        MODE_HIGH_SPEED_CRYSTAL_MULT = 3'h4,
        MODE_LOW_POWER_CRYSTAL = 3'h5,
        MODE_STANDARD_CRYSTAL = 3'h6
    } cfm_prim_mode_e;

    // System clock sources of the clock multiplexer
    typedef enum logic [1:0] {
        SRC_PRIMARY = 2'h0,
        SRC_SECONDARY = 2'h1,
        SRC_INTERNAL_OSC_MUX = 2'h2
    } cfm_clk_src_e;

    // Operating states of the clock control
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN = 2'b01,
        ST_PWR_MANAGED = 2'b10,
        ST_SLEEP = 2'b11
    } cfm_state_e;

    // Reset values
    localparam cfm_clk_src_e CLK_SEL_RST = SRC_INTERNAL_OSC_MUX;
    localparam cfm_state_e STATE_RST = ST_STARTUP;
    localparam logic FAIL_SAFE_RST = 1'b0;
    localparam logic FAIL_FLAG_RST = 1'b0;
    localparam logic PRIM_EN_RST = 1'b1;
    localparam logic SYNC_RST = 1'b0;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

endpackage

// file: src/cfm_edge_watch.sv
// Pin synchronisers and missing-edge detector of the clock fail monitor
`timescale 1ns/10ps
module cfm_edge_watch (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic prim_clk_i,
    input wire logic sec_clk_i,
    input wire logic slow_osc_i,
    input wire logic watch_sec_i,
    input wire logic armed_i,
    output logic fail_o
);
    import cfm_pkg::*;

    logic [SYNC_STAGES-1:0] prim_sync_r;
    logic [SYNC_STAGES-1:0] sec_sync_r;
    logic [SYNC_STAGES-1:0] slow_sync_r;
    logic [SYNC_STAGES-1:0] prim_sync_nxt;
    logic [SYNC_STAGES-1:0] sec_sync_nxt;
    logic [SYNC_STAGES-1:0] slow_sync_nxt;
    logic watched_last_r;
    logic watched_last_nxt;
    logic slow_last_r;
    logic slow_last_nxt;
    logic seen_r;
    logic seen_nxt;
    logic fail_r;
    logic fail_nxt;
    logic watched;
    logic watched_edge;
    logic slow_tick;

    // Shift pins through two stages; only the last stage feeds logic
    always_comb begin
        prim_sync_nxt = {prim_sync_r[SYNC_STAGES-2:0], prim_clk_i};
        sec_sync_nxt = {sec_sync_r[SYNC_STAGES-2:0], sec_clk_i};
        slow_sync_nxt = {slow_sync_r[SYNC_STAGES-2:0], slow_osc_i};
    end

    // Watched clock follows the source the multiplexer runs from
    assign watched = watch_sec_i ? sec_sync_r[SYNC_STAGES-1] : prim_sync_r[SYNC_STAGES-1];
    assign watched_edge = watched ^ watched_last_r;
    assign slow_tick = slow_sync_r[SYNC_STAGES-1] & ~slow_last_r;

    // One slow-oscillator period is the sampling window for an edge
    always_comb begin
        watched_last_nxt = watched;
        slow_last_nxt = slow_sync_r[SYNC_STAGES-1];
        fail_nxt = 1'b0;
        if (!armed_i) begin
            // Disarmed counts as seen, so arming always grants a full window
            seen_nxt = 1'b1;
        end else if (slow_tick) begin
            fail_nxt = ~seen_r & ~watched_edge;
            seen_nxt = watched_edge;
        end else begin
            seen_nxt = seen_r | watched_edge;
        end
    end

    // Registers only; a watched clock near 40 MHz, the bench system clock rate, aliases and is a known limit
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prim_sync_r <= '0;
            sec_sync_r <= '0;
            slow_sync_r <= '0;
            watched_last_r <= SYNC_RST;
            slow_last_r <= SYNC_RST;
            seen_r <= 1'b1;
            fail_r <= 1'b0;
        end else begin
            prim_sync_r <= prim_sync_nxt;
            sec_sync_r <= sec_sync_nxt;
            slow_sync_r <= slow_sync_nxt;
            watched_last_r <= watched_last_nxt;
            slow_last_r <= slow_last_nxt;
            seen_r <= seen_nxt;
            fail_r <= fail_nxt;
        end
    end

    assign fail_o = fail_r;

    // Fewer than two stages would let a metastable pin value reach the logic
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

endmodule // cfm_edge_watch

// file: verification/cfm_osc_model.sv
// Oscillator model: primary pin, secondary pin and free-running slow oscillator
`timescale 1ns/10ps
module cfm_osc_model #(
    parameter int PRIM_HALF = 101,
    parameter int SEC_HALF = 163,
    parameter int SLOW_HALF = 1003
) (
    input wire logic prim_run_i,
    input wire logic prim_en_i,
    input wire logic sec_run_i,
    output logic prim_clk_o,
    output logic sec_clk_o,
    output logic slow_osc_o
);
    // Slow oscillator never stops; a stopped or disabled source parks low
    initial begin
        prim_clk_o = 1'b0;
        sec_clk_o = 1'b0;
        slow_osc_o = 1'b0;
        fork
            forever #(SLOW_HALF) slow_osc_o = ~slow_osc_o;
            forever #(PRIM_HALF) prim_clk_o = prim_run_i && prim_en_i && !prim_clk_o;
            forever #(SEC_HALF) sec_clk_o = sec_run_i && !sec_clk_o;
        join
    end
endmodule  // cfm_osc_model

// file: verification/cfm_properties.sv
// Port-level checks of the clock fail monitor
`timescale 1ns/10ps
module cfm_properties
    import cfm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic prim_clk_i,
    input wire logic sec_clk_i,
    input wire logic slow_osc_i,
    input wire cfm_pkg::cfm_prim_mode_e prim_mode_i,
    input wire logic startup_timer_done_i,
    input wire logic pll_lock_done_i,
    input wire cfm_pkg::cfm_clk_src_e clk_sel_i,
    input wire logic clk_sel_wr_i,
    input wire logic pm_enter_i,
    input wire logic pm_sleep_i,
    input wire logic wake_irq_i,
    input wire logic fail_int_en_i,
    input wire logic fail_flag_clr_i,
    input wire cfm_pkg::cfm_clk_src_e clk_src_o,
    input wire logic fail_safe_o,
    input wire logic fail_flag_o,
    input wire logic startup_done_o,
    input wire logic prim_en_o,
    input wire logic cpu_run_o,
    input wire logic fail_wake_o,
    input wire logic monitor_armed_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Failure moves to the internal mux and raises the flag at once
    a_fail_sets_flag: assert property ($rose(fail_safe_o) |->
        fail_flag_o && clk_src_o == SRC_INTERNAL_OSC_MUX) else $error("fail without flag");
    // Only a mode entry may move the source away while fail-safe stands
    a_no_auto_return: assert property (fail_safe_o && !pm_enter_i |=>
        clk_src_o == SRC_INTERNAL_OSC_MUX) else $error("source left internal mux");
    a_pm_selects_src: assert property (pm_enter_i && cpu_run_o && startup_done_o |=>
        clk_src_o == $past(clk_sel_i) || fail_safe_o) else $error("mode entry source wrong");
    a_wake_on_fail: assert property (fail_wake_o |->
        fail_safe_o && cpu_run_o && $past(fail_int_en_i)) else $error("bad wake");
    a_wake_one_cycle: assert property (fail_wake_o |=> !fail_wake_o) else $error("wake long");
    // Crystal start-up runs from the internal block
    a_startup_internal: assert property (cpu_run_o && !startup_done_o |->
        clk_src_o == SRC_INTERNAL_OSC_MUX) else $error("start-up not on internal");
    a_unarmed_no_flag: assert property ($rose(fail_flag_o) |->
        $past(monitor_armed_o) || $past(monitor_armed_o, 2)) else $error("flag while unarmed");
    a_startup_prim_off: assert property (pm_enter_i && cpu_run_o && !startup_done_o &&
        clk_sel_i != SRC_PRIMARY |=> !prim_en_o) else $error("primary kept on");
    c_fail: cover property ($rose(fail_safe_o));
    c_wake: cover property (fail_wake_o);
    c_pm_startup: cover property (pm_enter_i && cpu_run_o && !startup_done_o);
endmodule  // cfm_properties

bind cfm_fail_safe_monitor cfm_properties i_props (.*);

// file: verification/test_cfm_fail_safe_monitor.sv
// Self-checking bench for the clock fail monitor
`timescale 1ns/10ps
module test_cfm_fail_safe_monitor;
    import cfm_pkg::*;
    typedef struct {string name; logic [7:0] mask; logic [7:0] val; int wk;} cfm_note_s;
    logic sys_clk_i, rst_n_i, prim_clk_i, sec_clk_i, slow_osc_i, prim_run, sec_run, xtal;
    cfm_prim_mode_e prim_mode_i;
    cfm_clk_src_e clk_sel_i, clk_src_o;
    logic startup_timer_done_i, pll_lock_done_i, clk_sel_wr_i, pm_enter_i, pm_sleep_i;
    logic wake_irq_i, fail_int_en_i, fail_flag_clr_i, fail_safe_o, fail_flag_o;
    logic startup_done_o, prim_en_o, cpu_run_o, fail_wake_o, monitor_armed_o;
    int num_errors = 0, total_checks = 0, cycles = 0, seed = 11, k, wake_cnt = 0;
    cfm_note_s notes[$];
    event look_ev;
    // Observed bits: source, fail-safe, flag, done, prim enable, run, armed
    wire [7:0] obs = {clk_src_o, fail_safe_o, fail_flag_o, startup_done_o, prim_en_o,
        cpu_run_o, monitor_armed_o};

    cfm_fail_safe_monitor i_dut (.*);
    cfm_osc_model i_osc (.prim_run_i(prim_run), .prim_en_i(prim_en_o), .sec_run_i(sec_run),
        .prim_clk_o(prim_clk_i), .sec_clk_o(sec_clk_i), .slow_osc_o(slow_osc_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // Note an expectation at the settled half of the cycle, then let the watcher judge
    // A wake count of -1 means the wake pulses are not judged by this note
    task automatic expect_obs(input string name, input logic [7:0] mask, input logic [7:0] val,
            input int wk = -1);
        @(negedge sys_clk_i);
        notes.push_back('{name, mask, val, wk});
        ->look_ev;
        @(posedge sys_clk_i);
    endtask
    // Strobes {select write, flag clear, mode entry, wake}; an idle edge follows
    // so that back-to-back calls never drive a strobe twice in one step
    task automatic pulse(input logic [3:0] p);
        {clk_sel_wr_i, fail_flag_clr_i, pm_enter_i, wake_irq_i} <= p;
        @(posedge sys_clk_i);
        {clk_sel_wr_i, fail_flag_clr_i, pm_enter_i, wake_irq_i} <= 4'h0;
        @(posedge sys_clk_i);
    endtask
    // Bounded poll of fail-safe (1) or start-up done (0); running out is a mismatch
    task automatic wait_on(input logic use_fs);
        for (k = 0; k < 600 && (use_fs ? fail_safe_o : startup_done_o) !== 1'b1; k++)
            @(posedge sys_clk_i);
        if (k == 600) begin
            num_errors++;
            $display("[ERR] %s expected 1 seen 0", use_fs ? "fail_safe_o" : "startup_done_o");
        end
    endtask
    task automatic do_reset(input cfm_prim_mode_e m);
        rst_n_i <= 1'b0;
        prim_mode_i <= m;
        {startup_timer_done_i, pll_lock_done_i} <= 2'h0;
        cyc(16);
        rst_n_i <= 1'b1;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watcher: oldest note against the outputs of this cycle
    always @(look_ev) begin
        cfm_note_s n;
        n = notes.pop_front();
        total_checks++;
        if ((obs & n.mask) !== n.val) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n.name, n.val, obs & n.mask);
        end
        if (n.wk >= 0) begin
            total_checks++;
            if (wake_cnt != n.wk) begin
                num_errors++;
                $display("[ERR] %s wakes expected %0d seen %0d", n.name, n.wk, wake_cnt);
            end
        end
    end

    // Wake pulse counted at the settled half; a one-cycle pulse counts once
    always @(negedge sys_clk_i) begin
        if (fail_wake_o === 1'b1) wake_cnt++;
    end

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        prim_mode_i = MODE_EXTERNAL_CLOCK_INPUT;
        clk_sel_i = SRC_PRIMARY;
        {startup_timer_done_i, pll_lock_done_i, clk_sel_wr_i, pm_enter_i, pm_sleep_i} = 5'h00;
        {wake_irq_i, fail_int_en_i, fail_flag_clr_i, prim_run, sec_run} = 5'h03;
        @(posedge sys_clk_i);
        // Each primary mode: crystal kinds wait for the start-up timer, the multiplied one also for lock; others arm at once
        for (int m = 0; m < 7; m++) begin
            do_reset(cfm_prim_mode_e'(m));
            cyc(4);
            xtal = (m >= 3);
            expect_obs("start", 8'hc9, xtal ? 8'h80 : 8'h09);
            startup_timer_done_i <= 1'b1;
            cyc(4);
            if (m == 4) expect_obs("lock", 8'h08, 8'h00);
            pll_lock_done_i <= 1'b1;
            wait_on(1'b0);
            expect_obs("stable", 8'hc9, 8'h09);
        end
        $display("test modes done");
        // Failure in run, then random select writes must be refused
        prim_run <= 1'b0;
        wait_on(1'b1);
        expect_obs("run fail", 8'hf0, 8'hb0, 0);
        prim_run <= 1'b1;
        repeat (4) begin
            clk_sel_i <= cfm_clk_src_e'(2'($random(seed)) & 2'h1);
            pulse(4'h8);
            cyc(200);
            expect_obs("held", 8'he0, 8'ha0);
        end
        pulse(4'h4);
        expect_obs("flag clear", 8'h30, 8'h20);
        $display("test run fail done");
        // Idle mode on secondary, interrupt enabled, secondary dies
        clk_sel_i <= SRC_SECONDARY;
        fail_int_en_i <= 1'b1;
        pulse(4'h2);
        expect_obs("pm entry", 8'hf2, 8'h40);
        cyc(300);
        expect_obs("pm watch", 8'hf3, 8'h41);
        sec_run <= 1'b0;
        wait_on(1'b1);
        expect_obs("pm wake", 8'hf2, 8'hb2, 1);
        $display("test pm wake done");
        // Same with interrupt off: stays idle until a wake interrupt
        sec_run <= 1'b1;
        fail_int_en_i <= 1'b0;
        pulse(4'h2);
        cyc(300);
        sec_run <= 1'b0;
        wait_on(1'b1);
        expect_obs("pm stay", 8'he2, 8'ha0, 1);
        pulse(4'h1);
        expect_obs("idle wake", 8'he2, 8'ha2);
        $display("test pm stay done");
        // Crystal that never starts: no flag; sleep entry in start-up drops the primary
        prim_run <= 1'b0;
        sec_run <= 1'b1;
        do_reset(MODE_LOW_POWER_CRYSTAL);
        cyc(400);
        expect_obs("no start", 8'hfd, 8'h84);
        pm_sleep_i <= 1'b1;
        pulse(4'h2);
        expect_obs("pm in startup", 8'h06, 8'h00);
        $display("test dead crystal done");
        // Wake from sleep restarts the primary and arms once it is stable
        prim_run <= 1'b1;
        pulse(4'h1);
        expect_obs("sleep wake", 8'hcf, 8'h86);
        startup_timer_done_i <= 1'b1;
        wait_on(1'b0);
        expect_obs("wake stable", 8'hc9, 8'h09);
        $display("test sleep wake done");
        cyc(2);
        wrap_up();
    end
endmodule  // test_cfm_fail_safe_monitor
